// *** hdl/mprr_ctrl.sv ***
// Notes on behaviour
// - refresh enable flag, bit 2 at BAh
// - flag set keeps refresh running in low power
// - refresh type latched when I/O reset sampled
// - master reset sample clears refresh enable flag
// - I/O reset leaves refresh enable flag alone
// - self refresh exit issues one CBR cycle
// - system reset rises whenever either reset asserts
// - system reset gates PLLs and stalls CPU
// - master reset restores defaults, timer 4 ms
// - wake keeps timer, reset until it expires
// - entering low power raises system reset at once
// - termination forced unless both resets high
// - power outputs take programmed low-power levels
// - low-power refresh timed from 32 kHz rate
// - only master reset resets the clock block
`timescale 1ns/10ps
`default_nettype none

`include "mprr_cfg.svh"

module mprr_ctrl #(
  // cycles of one start-up timer step
  parameter int unsigned StartupUnitCycles =
    `MPRR_STARTUP_UNIT_US * (`MPRR_CLK_HZ / `MPRR_HZ_PER_MHZ),
  // cycles of one low-power refresh tick
  parameter int unsigned RefreshDivCycles = `MPRR_CLK_HZ / `MPRR_OSC_HZ
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // reset pins, low means asserted
  input wire logic masterResetInN,
  input wire logic ioPowerGoodResetN,
  // register port
  input wire logic [`MPRR_ADDR_W-1:0] regAddr,
  input wire logic [`MPRR_DATA_W-1:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [`MPRR_DATA_W-1:0] regRdData,
  // reset and clock gating
  output logic systemResetOut,
  output logic pllGateOff,
  output logic cpuStall,
  output logic rtcResetOut,
  output logic forceTermOut,
  // dram refresh control
  output logic cbrRefreshReq,
  output logic selfRefreshExitCbr,
  output logic selfRefreshActive,
  output logic refreshDisabled,
  // power control pins
  output logic powerCtrlOutA,
  output logic powerCtrlOutB
);
  import mprr_pkg::*;

  // ========================================================================
  // constants and helpers

  // last count of a timer step and of the refresh divider
  localparam logic [`MPRR_UNIT_CNT_W-1:0] UnitLast =
    `MPRR_UNIT_CNT_W'(StartupUnitCycles - 1);
  localparam logic [`MPRR_DIV_CNT_W-1:0] DivLast =
    `MPRR_DIV_CNT_W'(RefreshDivCycles - 1);

  // register address match
  function automatic logic mprr_hit(input logic [`MPRR_ADDR_W-1:0] a,
                                    input logic [`MPRR_ADDR_W-1:0] idx);
    mprr_hit = (a == idx);
  endfunction : mprr_hit

  mprr_regs_t r; // registered state
  mprr_regs_t next_r; // next state
  logic oscTick; // one-cycle low-power refresh enable
  logic [`MPRR_STEP_CNT_W-1:0] timerCode; // programmed timer steps minus one

  // ========================================================================
  // next-state logic
  always_comb begin
    next_r = r;
    // two-flop synchronisers on the reset pins
    next_r.mstS1 = masterResetInN;
    next_r.mstS2 = r.mstS1;
    next_r.ioS1 = ioPowerGoodResetN;
    next_r.ioS2 = r.ioS1;
    // pulses default low, read data only after a read
    next_r.cbrReq = 1'b0;
    next_r.exitCbr = 1'b0;
    next_r.rdData = `MPRR_RD_IDLE;
    timerCode = r.clkCtrl[`MPRR_TIMER_MSB:`MPRR_TIMER_LSB];
    // free-running divider standing in for the 32 kHz rate
    oscTick = (r.divCnt == DivLast);
    if (oscTick) begin
      next_r.divCnt = '0;
    end else begin
      next_r.divCnt = r.divCnt + `MPRR_DIV_CNT_W'(1);
    end

    // register writes
    if (regWr) begin
      if (mprr_hit(regAddr, `MPRR_IDX_CLK_CTRL)) begin
        next_r.clkCtrl = regWrData;
      end else if (mprr_hit(regAddr, `MPRR_IDX_MISC3)) begin
        next_r.misc3 = regWrData;
      end
    end

    // register reads, answered in the next cycle
    if (regRd) begin
      if (mprr_hit(regAddr, `MPRR_IDX_CLK_CTRL)) begin
        next_r.rdData = r.clkCtrl;
      end else if (mprr_hit(regAddr, `MPRR_IDX_MISC3)) begin
        next_r.rdData = r.misc3;
      end else if (mprr_hit(regAddr, `MPRR_IDX_STATUS)) begin
        next_r.rdData[`MPRR_ST_LOWPWR] = (r.state == MPRR_LOWPWR);
        next_r.rdData[`MPRR_ST_SELF] = r.lpSelf;
        next_r.rdData[`MPRR_ST_TERM] = r.forceTerm;
        next_r.rdData[`MPRR_ST_SYSRST] = r.sysRst;
        next_r.rdData[`MPRR_ST_LPEN] = r.lpRefEn;
      end else begin
        next_r.rdData = `MPRR_RD_IDLE;
      end
    end

    // power sequencer
    case (r.state)
      // held in reset until both inputs are released
      MPRR_RESET: begin
        if (r.mstS2 && r.ioS2) begin
          next_r.state = MPRR_STARTUP;
          next_r.unitCnt = '0;
          next_r.stepCnt = '0;
        end
      end
      // start-up timer runs (code + 1) steps
      MPRR_STARTUP: begin
        if (!r.ioS2) begin
          next_r.state = MPRR_RESET;
        end else if (r.unitCnt == UnitLast) begin
          next_r.unitCnt = '0;
          if (r.stepCnt == timerCode) begin
            next_r.state = MPRR_RUN;
          end else begin
            next_r.stepCnt = r.stepCnt + `MPRR_STEP_CNT_W'(1);
          end
        end else begin
          next_r.unitCnt = r.unitCnt + `MPRR_UNIT_CNT_W'(1);
        end
      end
      // normal operation, I/O reset enters low power
      MPRR_RUN: begin
        if (!r.ioS2) begin
          next_r.state = MPRR_LOWPWR;
          next_r.lpSelf = r.misc3[`MPRR_BIT_SELF_REF];
          next_r.lpRefEn = r.misc3[`MPRR_BIT_LP_REF_EN];
        end
      end
      // low power: refresh as latched, wake keeps the timer setting
      MPRR_LOWPWR: begin
        if (r.ioS2) begin
          next_r.state = MPRR_STARTUP;
          next_r.unitCnt = '0;
          next_r.stepCnt = '0;
          next_r.exitCbr = r.lpRefEn && r.lpSelf;
        end else if (r.lpRefEn && !r.lpSelf && oscTick) begin
          next_r.cbrReq = 1'b1;
        end
      end
      default: begin
        next_r.state = MPRR_RESET;
      end
    endcase

    // master reset wins over everything, I/O reset touches no register
    if (!r.mstS2) begin
      next_r.clkCtrl = `MPRR_CLK_CTRL_RST;
      next_r.misc3 = `MPRR_MISC3_RST;
      next_r.state = MPRR_RESET;
      next_r.lpSelf = 1'b0;
      next_r.lpRefEn = 1'b0;
      next_r.cbrReq = 1'b0;
      next_r.exitCbr = 1'b0;
    end

    // registered outputs from the coming state, termination and clock block reset from the synchronised pins
    next_r.sysRst = (next_r.state != MPRR_RUN);
    next_r.forceTerm = !(r.mstS2 && r.ioS2);
    next_r.rtcRst = !r.mstS2;
    next_r.selfAct = (next_r.state == MPRR_LOWPWR) && next_r.lpRefEn && next_r.lpSelf;
    next_r.refOff = (next_r.state == MPRR_LOWPWR) && !next_r.lpRefEn;
    if (next_r.state == MPRR_LOWPWR) begin
      next_r.pwrA = next_r.misc3[`MPRR_BIT_PWR_A_LP];
      next_r.pwrB = next_r.misc3[`MPRR_BIT_PWR_B_LP];
    end else begin
      next_r.pwrA = next_r.misc3[`MPRR_BIT_PWR_A_RUN];
      next_r.pwrB = next_r.misc3[`MPRR_BIT_PWR_B_RUN];
    end
  end

  // ========================================================================
  // state register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      r <= '{mstS1: 1'b0, mstS2: 1'b0, ioS1: 1'b0, ioS2: 1'b0,
             state: MPRR_RESET, clkCtrl: `MPRR_CLK_CTRL_RST,
             misc3: `MPRR_MISC3_RST, unitCnt: '0, stepCnt: '0, divCnt: '0,
             lpSelf: 1'b0, lpRefEn: 1'b0, sysRst: 1'b1, forceTerm: 1'b1,
             rtcRst: 1'b1, cbrReq: 1'b0, exitCbr: 1'b0, selfAct: 1'b0,
             refOff: 1'b0, pwrA: 1'b0, pwrB: 1'b0, rdData: `MPRR_RD_IDLE};
    end else begin
      r <= next_r;
    end
  end

  // ========================================================================
  // outputs
  assign regRdData = r.rdData;
  assign systemResetOut = r.sysRst;
  assign pllGateOff = r.sysRst;
  assign cpuStall = r.sysRst;
  assign rtcResetOut = r.rtcRst;
  assign forceTermOut = r.forceTerm;
  assign cbrRefreshReq = r.cbrReq;
  assign selfRefreshExitCbr = r.exitCbr;
  assign selfRefreshActive = r.selfAct;
  assign refreshDisabled = r.refOff;
  assign powerCtrlOutA = r.pwrA;
  assign powerCtrlOutB = r.pwrB;

  // ========================================================================
  // checks

  // no refresh activity in low power when not enabled
  property p_refOff;
    @(posedge clk) disable iff (!rstn)
    (r.state == MPRR_LOWPWR && !r.lpRefEn) |-> (!r.cbrReq && !r.selfAct && r.refOff);
  endproperty
  a_refOff: assert property (p_refOff) else $error("refresh active while disabled");

  // enabled CBR refresh requests on each tick
  property p_cbrTick;
    @(posedge clk) disable iff (!rstn)
    (r.state == MPRR_LOWPWR && r.lpRefEn && !r.lpSelf && oscTick && !r.ioS2 && r.mstS2)
      |=> r.cbrReq;
  endproperty
  a_cbrTick: assert property (p_cbrTick) else $error("missed low-power refresh");

  // latched refresh type holds through low power
  property p_typeHold;
    @(posedge clk) disable iff (!rstn)
    (r.state == MPRR_LOWPWR && $past(r.state) == MPRR_LOWPWR) |-> $stable(r.lpSelf);
  endproperty
  a_typeHold: assert property (p_typeHold) else $error("refresh type changed");

  // master reset clears the refresh enable flag
  property p_flagClr;
    @(posedge clk) disable iff (!rstn)
    !r.mstS2 |=> !r.misc3[`MPRR_BIT_LP_REF_EN] && r.clkCtrl == `MPRR_CLK_CTRL_RST;
  endproperty
  a_flagClr: assert property (p_flagClr) else $error("flag survived master reset");

  // I/O reset alone leaves the flag untouched
  property p_flagKeep;
    @(posedge clk) disable iff (!rstn)
    (r.mstS2 && !(regWr && regAddr == `MPRR_IDX_MISC3))
      |=> $stable(r.misc3[`MPRR_BIT_LP_REF_EN]);
  endproperty
  a_flagKeep: assert property (p_flagKeep) else $error("flag changed by I/O reset");

  // exit CBR is a single pulse right after low power
  property p_exitOne;
    @(posedge clk) disable iff (!rstn)
    r.exitCbr |-> $past(r.state) == MPRR_LOWPWR && r.state == MPRR_STARTUP ##1 !r.exitCbr;
  endproperty
  a_exitOne: assert property (p_exitOne) else $error("bad self refresh exit pulse");

  // either reset asserted raises system reset next cycle
  property p_sysRst;
    @(posedge clk) disable iff (!rstn)
    (!r.mstS2 || !r.ioS2) |=> r.sysRst;
  endproperty
  a_sysRst: assert property (p_sysRst) else $error("system reset not raised");

  // start-up keeps the core held
  property p_hold;
    @(posedge clk) disable iff (!rstn)
    (r.state != MPRR_RUN) |-> (r.sysRst && pllGateOff && cpuStall);
  endproperty
  a_hold: assert property (p_hold) else $error("core released early");

  // termination released one cycle after both synchronised inputs are high
  property p_term;
    @(posedge clk) disable iff (!rstn)
    (r.mstS2 && r.ioS2) |=> !r.forceTerm;
  endproperty
  a_term: assert property (p_term) else $error("termination wrong");

  // termination forced one cycle after either synchronised input is low
  property p_termOn;
    @(posedge clk) disable iff (!rstn)
    (!r.mstS2 || !r.ioS2) |=> r.forceTerm;
  endproperty
  a_termOn: assert property (p_termOn) else $error("termination not forced");

  // clock block reset follows the master input only
  property p_rtc;
    @(posedge clk) disable iff (!rstn)
    (r.mstS2 && !r.ioS2) |=> !r.rtcRst;
  endproperty
  a_rtc: assert property (p_rtc) else $error("I/O reset reached clock block");

endmodule : mprr_ctrl

`default_nettype wire

// *** inc/mprr_cfg.svh ***
`ifndef MPRR_CFG_SVH
`define MPRR_CFG_SVH

// ==========================================================================
// register bus geometry
`define MPRR_ADDR_W 8
`define MPRR_DATA_W 8

// ==========================================================================
// register indices
`define MPRR_IDX_CLK_CTRL 8'h8F
`define MPRR_IDX_MISC3 8'hBA
`define MPRR_IDX_STATUS 8'hBC

// ==========================================================================
// reset values
`define MPRR_CLK_CTRL_RST 8'h00
`define MPRR_MISC3_RST 8'h00
`define MPRR_RD_IDLE 8'h00

// ==========================================================================
// field positions, clock control
`define MPRR_TIMER_LSB 0
`define MPRR_TIMER_MSB 2

// ==========================================================================
// field positions, misc config three
`define MPRR_BIT_PWR_A_RUN 0
`define MPRR_BIT_PWR_B_RUN 1
`define MPRR_BIT_LP_REF_EN 2
`define MPRR_BIT_SELF_REF 3
`define MPRR_BIT_PWR_A_LP 4
`define MPRR_BIT_PWR_B_LP 5

// ==========================================================================
// field positions, status
`define MPRR_ST_LOWPWR 0
`define MPRR_ST_SELF 1
`define MPRR_ST_TERM 2
`define MPRR_ST_SYSRST 3
`define MPRR_ST_LPEN 4

// ==========================================================================
// timing
`define MPRR_CLK_HZ 25000000
`define MPRR_HZ_PER_MHZ 1000000
`define MPRR_STARTUP_UNIT_US 4000
`define MPRR_OSC_HZ 32768
`define MPRR_UNIT_CNT_W 20
`define MPRR_DIV_CNT_W 12
`define MPRR_STEP_CNT_W 3

`endif

// *** inc/mprr_pkg.sv ***
`default_nettype none

`include "mprr_cfg.svh"

// ==========================================================================
// shared types of the power and reset sequencer
package mprr_pkg;

  // sequencer states, one-hot
  typedef enum logic [3:0] {
    MPRR_RESET = 4'h1,
    MPRR_STARTUP = 4'h2,
    MPRR_RUN = 4'h4,
    MPRR_LOWPWR = 4'h8
  } mprr_state_t;

  // whole state of the sequencer
  typedef struct packed {
    logic mstS1;
    logic mstS2;
    logic ioS1;
    logic ioS2;
    mprr_state_t state;
    logic [`MPRR_DATA_W-1:0] clkCtrl;
    logic [`MPRR_DATA_W-1:0] misc3;
    logic [`MPRR_UNIT_CNT_W-1:0] unitCnt;
    logic [`MPRR_STEP_CNT_W-1:0] stepCnt;
    logic [`MPRR_DIV_CNT_W-1:0] divCnt;
    logic lpSelf;
    logic lpRefEn;
    logic sysRst;
    logic forceTerm;
    logic rtcRst;
    logic cbrReq;
    logic exitCbr;
    logic selfAct;
    logic refOff;
    logic pwrA;
    logic pwrB;
    logic [`MPRR_DATA_W-1:0] rdData;
  } mprr_regs_t;

endpackage : mprr_pkg

`default_nettype wire

// *** sim/mprr_power_src.sv ***
`timescale 1ns/10ps
`default_nettype none

// ==========================================================================
// power-on reset source and primary supply
module mprr_power_src #(
  // scaled cold-boot hold of master reset
  parameter int HoldCycles = 50,
  // scaled warm-reset hold of master reset
  parameter int WarmCycles = 30
) (
  // clock
  input wire logic clk,
  // reset pins, low means asserted
  output logic masterResetInN,
  output logic ioPowerGoodResetN
);
  logic powered; // set once fully powered up

  // both pins start low from one power-on source
  initial begin
    masterResetInN = 1'b0;
    ioPowerGoodResetN = 1'b0;
    powered = 1'b0;
  end

  // hold master reset, then release both together
  task cold_boot;
    repeat (HoldCycles) @(posedge clk);
    masterResetInN <= 1'b1;
    ioPowerGoodResetN <= 1'b1;
    powered = 1'b1;
  endtask : cold_boot

  // warm reset pulse on master reset only
  task warm_reset;
    @(posedge clk);
    masterResetInN <= 1'b0;
    repeat (WarmCycles) @(posedge clk);
    masterResetInN <= 1'b1;
  endtask : warm_reset

  // primary supply off, never before a full power-up
  task supply_off;
    @(posedge clk);
    if (powered) begin
      ioPowerGoodResetN <= 1'b0;
    end
  endtask : supply_off

  // primary supply back on
  task supply_on;
    @(posedge clk);
    ioPowerGoodResetN <= 1'b1;
  endtask : supply_on
endmodule : mprr_power_src

`default_nettype wire

// *** sim/test_micro_power_reset_refresh_ctrl.sv ***
`timescale 1ns/10ps
`default_nettype none

`include "mprr_cfg.svh"

// ==========================================================================
// testbench of the power and reset sequencer
module test_micro_power_reset_refresh_ctrl;
  localparam int Unit = 20; // cycles of one timer step
  localparam int Div = 8; // cycles of one refresh tick
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [`MPRR_ADDR_W-1:0] regAddr = 8'h00;
  logic [`MPRR_DATA_W-1:0] regWrData = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [`MPRR_DATA_W-1:0] regRdData;
  logic sysRst, pllGate, cpuStall, rtcRst, term, cbrReq, exitCbr, selfAct, refOff, pwrA, pwrB;
  wire logic mstN; // master reset pin
  wire logic ioN; // power-good reset pin
  int seed = 32'h3a2e2ce1;
  int fail_count = 0;
  int num_checks = 0;
  int clkModel = 0; // model of clock control
  int miscModel = 0; // model of misc config three
  int n, cbr, ext, exp;
  logic [7:0] m;
  int modes [3] = '{0, 4, 12};

  // clock
  always #20 clk = ~clk;

  // ==========================================================================
  // design and far side
  mprr_ctrl #(.StartupUnitCycles(Unit), .RefreshDivCycles(Div)) i_mprr_ctrl (
    .clk(clk), .rstn(rstn), .masterResetInN(mstN), .ioPowerGoodResetN(ioN),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .systemResetOut(sysRst), .pllGateOff(pllGate),
    .cpuStall(cpuStall), .rtcResetOut(rtcRst), .forceTermOut(term),
    .cbrRefreshReq(cbrReq), .selfRefreshExitCbr(exitCbr), .selfRefreshActive(selfAct),
    .refreshDisabled(refOff), .powerCtrlOutA(pwrA), .powerCtrlOutB(pwrB));
  mprr_power_src i_mprr_power_src (.clk(clk), .masterResetInN(mstN), .ioPowerGoodResetN(ioN));

  // ==========================================================================
  // shared tasks
  task chk(input string name, input logic [31:0] seen, input logic [31:0] expv);
    num_checks++;
    if (seen !== expv) begin
      fail_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", name, expv, seen);
    end
  endtask : chk

  // one-cycle write strobe
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask : wr

  // read, data sampled in the following cycle
  task rdChk(input logic [7:0] a, input int expv);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    @(negedge clk);
    chk("regRdData", regRdData, expv[7:0]);
  endtask : rdChk

  // count pulses for a span, or until system reset drops
  task watch(input int cyc, input bit untilRel, output int cnt, output int nc, output int ne);
    cnt = 0;
    nc = 0;
    ne = 0;
    while (cnt < cyc && !(untilRel && sysRst === 1'b0)) begin
      @(negedge clk);
      cnt++;
      nc += (cbrReq === 1'b1);
      ne += (exitCbr === 1'b1);
    end
  endtask : watch

  task done(input string name);
    $display("test %s done", name);
  endtask : done

  task conclude;
    $display("checks %0d failures %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude

  // watchdog against a hang
  initial begin
    #(40 * 20000);
    fail_count++;
    conclude();
  end

  // ==========================================================================
  // main sequence
  initial begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(negedge clk);
    chk("sysRst", sysRst, 1);
    chk("pllGate", pllGate, 1);
    chk("cpuStall", cpuStall, 1);
    chk("rtcRst", rtcRst, 1);
    chk("term", term, 1);
    i_mprr_power_src.cold_boot();
    watch(400, 1, n, cbr, ext);
    chk("coldWidth", n >= Unit && n <= Unit + 8, 1);
    chk("term", term, 0);
    chk("rtcRst", rtcRst, 0);
    rdChk(8'h8F, clkModel);
    rdChk(8'hBA, miscModel);
    rdChk(8'h55, 0);
    clkModel = $random(seed) & 7;
    wr(8'h8F, 8'(clkModel));
    rdChk(8'h8F, clkModel);
    clkModel = 1;
    wr(8'h8F, 8'(clkModel));
    done("coldboot");
    // low-power entry and wake for each refresh mode
    foreach (modes[i]) begin
      m = (8'($random(seed)) & 8'h33) | 8'(modes[i]);
      miscModel = m;
      wr(8'hBA, m);
      repeat (3) @(negedge clk);
      chk("pwrA", pwrA, m[0]);
      chk("pwrB", pwrB, m[1]);
      i_mprr_power_src.supply_off();
      repeat (4) @(negedge clk);
      chk("sysRst", sysRst, 1);
      chk("pllGate", pllGate, 1);
      chk("term", term, 1);
      chk("rtcRst", rtcRst, 0);
      chk("pwrA", pwrA, m[4]);
      chk("pwrB", pwrB, m[5]);
      chk("refOff", refOff, !m[2]);
      miscModel = m ^ 8'h08;
      wr(8'hBA, 8'(miscModel));
      // status: low power, latched type, termination, system reset, latched enable
      rdChk(8'hBC, {3'h0, m[2], 2'h3, m[3], 1'h1});
      watch(10 * Div, 0, n, cbr, ext);
      exp = (m[2] && !m[3]) ? 10 : 0;
      chk("cbrCount", exp == 0 ? cbr == 0 : cbr >= exp - 1 && cbr <= exp + 1, 1);
      chk("selfAct", selfAct, m[2] & m[3]);
      i_mprr_power_src.supply_on();
      watch(400, 1, n, cbr, ext);
      chk("exitCbr", ext, m[2] & m[3]);
      chk("wakeWidth", n >= 2 * Unit && n <= 2 * Unit + 8, 1);
      rdChk(8'hBA, miscModel);
      rdChk(8'h8F, clkModel);
      done("lowpower");
    end
    // warm reset clears registers
    wr(8'h8F, 8'h03);
    wr(8'hBA, 8'h04);
    fork
      i_mprr_power_src.warm_reset();
    join_none
    repeat (6) @(negedge clk);
    chk("sysRst", sysRst, 1);
    chk("rtcRst", rtcRst, 1);
    chk("term", term, 1);
    rdChk(8'hBA, 0);
    rdChk(8'h8F, 0);
    repeat (30) @(negedge clk);
    watch(400, 1, n, cbr, ext);
    chk("sysRst", sysRst, 0);
    done("warmreset");
    conclude();
  end
endmodule : test_micro_power_reset_refresh_ctrl

`default_nettype wire
